//--- uicc_pkg.sv
// uicc_pkg: register map, field positions and reset values of the counter
package uicc_pkg;

  // ------------------------------------------------------------------
  // bus geometry
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IDX_W  = 10;

  // ------------------------------------------------------------------
  // register indices, byte address is four times the index
  // ------------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_PRESET_LOW  = 10'h118;
  localparam logic [IDX_W-1:0] IDX_PRESET_HIGH = 10'h11a;
  localparam logic [IDX_W-1:0] IDX_PRESET_A    = 10'h11c;
  localparam logic [IDX_W-1:0] IDX_PRESET_B    = 10'h11d;
  localparam logic [IDX_W-1:0] IDX_PRESET_C    = 10'h11e;
  localparam logic [IDX_W-1:0] IDX_CTRL        = 10'h11f;
  localparam logic [IDX_W-1:0] IDX_CONFIG      = 10'h120;
  localparam logic [IDX_W-1:0] IDX_COUNT       = 10'h121;
  localparam logic [IDX_W-1:0] IDX_STATE       = 10'h122;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT    = 10'h123;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK    = 10'h124;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int unsigned CTRL_LOAD_BIT = 0;  // arm new start/compare value
  localparam int unsigned CTRL_RUN_BIT  = 1;  // start/enable
  localparam int unsigned CFG_DOWN_BIT  = 0;  // 1 = count down
  localparam int unsigned CFG_IRQ_BIT   = 1;  // hardware interrupt option
  localparam int unsigned CFG_FALL_BIT  = 2;  // 1 = falling edge counts
  localparam int unsigned CFG_W         = 3;
  localparam int unsigned ST_RUN_BIT    = 0;
  localparam int unsigned ST_PEND_BIT   = 1;
  localparam int unsigned IRQ_W         = 1;

  // ------------------------------------------------------------------
  // values after reset
  // ------------------------------------------------------------------
  localparam logic [7:0]       RST_BYTE = 8'h00;
  localparam logic [15:0]      RST_WORD = 16'h0000;
  localparam logic [CFG_W-1:0] RST_CFG  = 3'h0;
  localparam logic [IRQ_W-1:0] RST_IRQ  = 1'h0;

  // ------------------------------------------------------------------
  // counter run state
  // ------------------------------------------------------------------
  typedef enum logic [0:0] {
    UICC_STOPPED = 1'b0,
    UICC_RUNNING = 1'b1
  } uicc_state_t;

endpackage

//--- uicc_edge_det.sv
// uicc_edge_det: detects rise and fall by comparing with the last sample
`timescale 1ns/1ps
module uicc_edge_det (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // sampled level
  input  wire logic level,
  // one-cycle edge pulses
  output wire logic rise,
  output wire logic fall
);

  logic prev_q;

  // previous sample; reset to 0 so a level already high counts as a rise
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= level;
    end
  end

  // each edge shows for exactly one cycle
  assign rise = level & ~prev_q;
  assign fall = ~level & prev_q;

endmodule // uicc_edge_det

//--- uicc_ctrl.sv
// uicc_ctrl: up/down event counter control with avalon-mm register access
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module uicc_ctrl #(
  parameter int unsigned CNT_W = 32
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // avalon-mm slave
  input  wire logic [11:0] address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output wire logic        waitrequest,
  // count pulse input from the universal input
  input  wire logic        countIn,
  // level interrupt
  output wire logic        irq
);

  // ------------------------------------------------------------------
  // bus slave: one wait state, then the answer
  // ------------------------------------------------------------------
  logic                      ack_q;
  wire                       req    = read | write;
  wire [uicc_pkg::IDX_W-1:0] idx    = address[11:2];
  wire                       wrDone = write & ack_q;
  wire [31:0]                beMask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                                       {8{byteenable[1]}}, {8{byteenable[0]}}};

  assign waitrequest = req & ~ack_q;

  // ack pulses one cycle after the request, then drops for the next one
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // ------------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------------
  logic [15:0]                presetLow_q, presetHigh_q;
  logic [7:0]                 presetA_q, presetB_q, presetC_q, ctrl_q;
  logic [uicc_pkg::CFG_W-1:0] cfg_q;
  logic [uicc_pkg::IRQ_W-1:0] irqStat_q, irqMask_q, irqStat_d;

  wire selLow   = idx == uicc_pkg::IDX_PRESET_LOW;
  wire selHigh  = idx == uicc_pkg::IDX_PRESET_HIGH;
  wire selA     = idx == uicc_pkg::IDX_PRESET_A;
  wire selB     = idx == uicc_pkg::IDX_PRESET_B;
  wire selC     = idx == uicc_pkg::IDX_PRESET_C;
  wire selCtrl  = idx == uicc_pkg::IDX_CTRL;
  wire selCfg   = idx == uicc_pkg::IDX_CONFIG;
  wire selCount = idx == uicc_pkg::IDX_COUNT;
  wire selState = idx == uicc_pkg::IDX_STATE;
  wire selStat  = idx == uicc_pkg::IDX_IRQ_STAT;
  wire selMask  = idx == uicc_pkg::IDX_IRQ_MASK;

  // merge of written lanes into the old value
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [31:0] bm);
    merge = (old & ~bm) | (wd & bm);
  endfunction

  wire [31:0] mLow  = merge({16'h0000, presetLow_q}, writedata, beMask);
  wire [31:0] mHigh = merge({16'h0000, presetHigh_q}, writedata, beMask);
  wire [31:0] mA    = merge({24'h00_0000, presetA_q}, writedata, beMask);
  wire [31:0] mB    = merge({24'h00_0000, presetB_q}, writedata, beMask);
  wire [31:0] mC    = merge({24'h00_0000, presetC_q}, writedata, beMask);
  wire [31:0] mCtrl = merge({24'h00_0000, ctrl_q}, writedata, beMask);
  wire [31:0] mCfg  = merge({29'h0000_0000, cfg_q}, writedata, beMask);
  wire [31:0] mMask = merge({31'h0000_0000, irqMask_q}, writedata, beMask);
  wire [uicc_pkg::IRQ_W-1:0] w1c = (wrDone & selStat & byteenable[0])
                                   ? writedata[uicc_pkg::IRQ_W-1:0]
                                   : {uicc_pkg::IRQ_W{1'b0}};

  // preset bytes: the value is only used once armed, so a half-written
  // preset never reaches the counter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      presetLow_q  <= uicc_pkg::RST_WORD;
      presetHigh_q <= uicc_pkg::RST_WORD;
      presetA_q    <= uicc_pkg::RST_BYTE;
      presetB_q    <= uicc_pkg::RST_BYTE;
      presetC_q    <= uicc_pkg::RST_BYTE;
    end else if (wrDone) begin
      if (selLow)  presetLow_q  <= mLow[15:0];
      if (selHigh) presetHigh_q <= mHigh[15:0];
      if (selA)    presetA_q    <= mA[7:0];
      if (selB)    presetB_q    <= mB[7:0];
      if (selC)    presetC_q    <= mC[7:0];
    end
  end

  // control, configuration, mask and interrupt status
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q    <= uicc_pkg::RST_BYTE;
      cfg_q     <= uicc_pkg::RST_CFG;
      irqMask_q <= uicc_pkg::RST_IRQ;
      irqStat_q <= uicc_pkg::RST_IRQ;
    end else begin
      if (wrDone && selCtrl) ctrl_q    <= mCtrl[7:0];
      if (wrDone && selCfg)  cfg_q     <= mCfg[uicc_pkg::CFG_W-1:0];
      if (wrDone && selMask) irqMask_q <= mMask[uicc_pkg::IRQ_W-1:0];
      irqStat_q <= irqStat_d;
    end
  end

  // ------------------------------------------------------------------
  // edge detection of control bits and of the count input
  // ------------------------------------------------------------------
  logic loadRise, runRise, runFall, inRise, inFall;

  uicc_edge_det u_load_edge (
    .clk   (clk),
    .rst_n (rst_n),
    .level (ctrl_q[uicc_pkg::CTRL_LOAD_BIT]),
    .rise  (loadRise),
    .fall  ()
  );

  uicc_edge_det u_run_edge (
    .clk   (clk),
    .rst_n (rst_n),
    .level (ctrl_q[uicc_pkg::CTRL_RUN_BIT]),
    .rise  (runRise),
    .fall  (runFall)
  );

  uicc_edge_det u_in_edge (
    .clk   (clk),
    .rst_n (rst_n),
    .level (countIn),
    .rise  (inRise),
    .fall  (inFall)
  );

  wire dirDown = cfg_q[uicc_pkg::CFG_DOWN_BIT];
  wire hwIrqEn = cfg_q[uicc_pkg::CFG_IRQ_BIT];
  wire pulse   = cfg_q[uicc_pkg::CFG_FALL_BIT] ? inFall : inRise;

  // ------------------------------------------------------------------
  // counter core
  // ------------------------------------------------------------------
  uicc_pkg::uicc_state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d, start_q, start_d, target_q, target_d;
  logic [CNT_W-1:0] armed_q, base;
  logic             pend_q, pend_d, termEv;

  wire [CNT_W-1:0] presetCnt = CNT_W'({presetHigh_q, presetLow_q});
  wire             running   = state_q == uicc_pkg::UICC_RUNNING;
  wire             reinit    = runRise & ctrl_q[uicc_pkg::CTRL_LOAD_BIT];
  wire             step      = running & pulse & ~reinit;
  // with load rising in the same cycle as the run rise, the preset is fresh; else armed_q is used
  wire [CNT_W-1:0] newVal    = loadRise ? presetCnt : armed_q;

  // run state follows the run bit edges
  always_comb begin
    case (state_q)
      uicc_pkg::UICC_STOPPED: begin
        state_d = runRise ? uicc_pkg::UICC_RUNNING
                          : uicc_pkg::UICC_STOPPED;
      end
      uicc_pkg::UICC_RUNNING: begin
        state_d = runFall ? uicc_pkg::UICC_STOPPED
                          : uicc_pkg::UICC_RUNNING;
      end
      default: state_d = uicc_pkg::UICC_STOPPED;
    endcase
  end

  // next count; a run rise without load leaves every value alone
  always_comb begin
    cnt_d    = cnt_q;
    start_d  = start_q;
    target_d = target_q;
    pend_d   = pend_q;
    termEv   = 1'b0;
    base     = cnt_q;
    if (reinit) begin
      start_d  = newVal;
      target_d = newVal;
      cnt_d    = dirDown ? newVal : '0;
      pend_d   = 1'b0;
    end else if (step) begin
      if (pend_q) begin
        if (dirDown) begin
          base    = cnt_q + armed_q - start_q;
          start_d = armed_q;
        end else begin
          target_d = armed_q;
        end
        pend_d = 1'b0;
      end
      if (dirDown) begin
        if (base <= CNT_W'(1)) begin
          cnt_d  = start_d;
          termEv = 1'b1;
        end else begin
          cnt_d = base - CNT_W'(1);
        end
      end else if (target_d != '0 && base + CNT_W'(1) >= target_d) begin
        cnt_d  = '0;
        termEv = 1'b1;
      end else begin
        cnt_d = base + CNT_W'(1);
      end
    end
    // a reinit consumes the fresh preset itself, so nothing stays pending
    if (loadRise && !reinit) pend_d = 1'b1;
  end

  // counter registers; zero after reset so up counting starts at zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q  <= uicc_pkg::UICC_STOPPED;
      cnt_q    <= '0;
      start_q  <= '0;
      target_q <= '0;
      armed_q  <= '0;
      pend_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      start_q  <= start_d;
      target_q <= target_d;
      pend_q   <= pend_d;
      if (loadRise) armed_q <= presetCnt;
    end
  end

  // ------------------------------------------------------------------
  // interrupt: sticky status, set wins over a same-cycle clear
  // ------------------------------------------------------------------
  wire [uicc_pkg::IRQ_W-1:0] irqSet = {uicc_pkg::IRQ_W{termEv & hwIrqEn}};

  assign irqStat_d = (irqStat_q & ~w1c) | irqSet;
  assign irq       = |(irqStat_q & irqMask_q);

  // ------------------------------------------------------------------
  // read mux, latched at the wait cycle so data stands with the answer
  // ------------------------------------------------------------------
  wire [31:0] stateWord = {30'h0000_0000, pend_q, running};
  wire [31:0] cntWord   = 32'(cnt_q);
  wire [31:0] rdMux =
      selLow   ? {16'h0000, presetLow_q}             :
      selHigh  ? {16'h0000, presetHigh_q}            :
      selA     ? {24'h00_0000, presetA_q}            :
      selB     ? {24'h00_0000, presetB_q}            :
      selC     ? {24'h00_0000, presetC_q}            :
      selCtrl  ? {24'h00_0000, ctrl_q}               :
      selCfg   ? {29'h0000_0000, cfg_q}              :
      selCount ? cntWord                             :
      selState ? stateWord                           :
      selStat  ? {31'h0000_0000, irqStat_q}          :
      selMask  ? {31'h0000_0000, irqMask_q}          :
                 32'h0000_0000;                      // unmapped reads zero

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      readdata <= 32'h0000_0000;
    end else if (read && !ack_q) begin
      readdata <= rdMux;
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_bus_wait;
    req && waitrequest;
  endsequence

  sequence s_up_adopt;
    step && pend_q && !dirDown;
  endsequence

  sequence s_down_adopt;
    step && pend_q && dirDown;
  endsequence

  a_bus_answer: assert property (s_bus_wait |=> !waitrequest)
    else $error("bus request not answered after one wait cycle");

  a_load_arms: assert property (
    loadRise |=> armed_q == $past(presetCnt) && pend_q == !$past(reinit))
    else $error("load edge did not arm the preset");

  a_run_starts: assert property (runRise |=> running)
    else $error("run rise did not start the counter");

  a_run_stops: assert property (runFall |=> !running)
    else $error("run fall did not stop the counter");

  a_resume_keeps: assert property (
    runRise && !reinit |=> cnt_q == $past(cnt_q))
    else $error("restart without load changed the count");

  a_pend_waits: assert property (
    pend_q && !pulse && !reinit |=> pend_q && start_q == $past(start_q))
    else $error("armed value applied without a count edge");

  a_up_adopt: assert property (
    s_up_adopt |=> target_q == $past(armed_q))
    else $error("new compare value not adopted");

  a_down_adjust: assert property (
    s_down_adopt |=> start_q == $past(armed_q))
    else $error("new start value not adopted");

  a_reinit_load: assert property (
    reinit |=> cnt_q == ($past(dirDown) ? start_q : '0) && !pend_q)
    else $error("run rise with load did not reinitialise");

  a_irq_gate: assert property (
    $rose(irqStat_q[0]) |-> $past(termEv && hwIrqEn))
    else $error("interrupt status set without enabled event");

  a_up_reset: assert property (
    termEv && !dirDown |=> cnt_q == '0)
    else $error("up count not reset at compare");

  a_down_reload: assert property (
    termEv && dirDown |=> cnt_q == start_q)
    else $error("down count not reloaded at zero");

  a_edge_once: assert property (loadRise |=> !loadRise)
    else $error("control edge seen twice");

endmodule // uicc_ctrl

//--- uicc_pulse_src.sv
// uicc_pulse_src: model of the count pulse source on a universal input
`timescale 1ns/1ps
module uicc_pulse_src (
  // clock
  input  wire logic clk,
  // pulse line toward the counter
  output logic      countIn
);
  // idle low, so the first pulse of a burst is a clean rising edge
  initial countIn = 1'b0;

  // n pulses, hiLen cycles high, loLen cycles low (loLen >= 1);
  // long widths stand for a slow encoder, short ones for a fast one
  task automatic pulses(input int n, input int hiLen, input int loLen);
    repeat (n) begin
      @(posedge clk);
      countIn <= 1'b1;
      repeat (hiLen) @(posedge clk);
      countIn <= 1'b0;
      repeat (loLen - 1) @(posedge clk);
    end
  endtask
endmodule // uicc_pulse_src

//--- uicc_ctrl_tb.sv
// uicc_ctrl_tb: self-checking bench of the event counter control block
`timescale 1ns/1ps
module uicc_ctrl_tb;
  // ------------------------------------------------------------------
  // byte addresses, four times the register index
  // ------------------------------------------------------------------
  localparam logic [11:0] A_LOW  = {uicc_pkg::IDX_PRESET_LOW, 2'b00};
  localparam logic [11:0] A_HIGH = {uicc_pkg::IDX_PRESET_HIGH, 2'b00};
  localparam logic [11:0] A_BA   = {uicc_pkg::IDX_PRESET_A, 2'b00};
  localparam logic [11:0] A_BB   = {uicc_pkg::IDX_PRESET_B, 2'b00};
  localparam logic [11:0] A_BC   = {uicc_pkg::IDX_PRESET_C, 2'b00};
  localparam logic [11:0] A_CTRL = {uicc_pkg::IDX_CTRL, 2'b00};
  localparam logic [11:0] A_CFG  = {uicc_pkg::IDX_CONFIG, 2'b00};
  localparam logic [11:0] A_CNT  = {uicc_pkg::IDX_COUNT, 2'b00};
  localparam logic [11:0] A_ST   = {uicc_pkg::IDX_STATE, 2'b00};
  localparam logic [11:0] A_IS   = {uicc_pkg::IDX_IRQ_STAT, 2'b00};
  localparam logic [11:0] A_IM   = {uicc_pkg::IDX_IRQ_MASK, 2'b00};

  logic        clk;
  logic        rst_n;
  logic [11:0] address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        countIn;
  logic        irq;
  int          nMismatch;
  int          compares;

  // free-running 50 MHz clock
  always #10 clk = ~clk;

  uicc_pulse_src src (
    .clk    (clk),
    .countIn(countIn)
  );

  uicc_ctrl #(.CNT_W(32)) dut (
    .clk        (clk),
    .rst_n      (rst_n),
    .address    (address),
    .read       (read),
    .write      (write),
    .writedata  (writedata),
    .byteenable (byteenable),
    .readdata   (readdata),
    .waitrequest(waitrequest),
    .countIn    (countIn),
    .irq        (irq)
  );

  // ------------------------------------------------------------------
  // reporting and bus tasks
  // ------------------------------------------------------------------
  task automatic conclude;
    $display("compares %0d mismatches %0d", compares, nMismatch);
    if (nMismatch == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      nMismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmpIrq(input logic exp);
    compares++;
    if (irq !== exp) begin
      nMismatch++;
      $display("BAD t=%0t irq=%h exp=%h", $time, irq, exp);
    end
  endtask

  // one avalon transfer; the request stands until waitrequest is seen low
  // at a rising edge, and read data is taken at that same edge
  task automatic bus(input logic rd, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    int i;
    q = 32'h0000_0000;
    @(posedge clk);
    read       <= rd;
    write      <= !rd;
    address    <= a;
    writedata  <= d;
    byteenable <= be;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) begin
        q = readdata;
        break;
      end
    end
    read  <= 1'b0;
    write <= 1'b0;
    if (i == 50) begin
      nMismatch++;
      conclude();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] be = 4'hf);
    logic [31:0] q;
    bus(1'b0, a, d, be, q);
  endtask

  task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b1, a, 32'h0000_0000, 4'hf, q);
    cmp(q, exp);
  endtask

  // count update lands one cycle after a rising edge
  task automatic pulse(input int n);
    src.pulses(n, 1, 2);
    repeat (4) @(posedge clk);
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic testRegs;
    logic [11:0] regs[11];
    regs = '{A_LOW, A_HIGH, A_BA, A_BB, A_BC, A_CTRL, A_CFG, A_CNT,
             A_ST, A_IS, A_IM};
    foreach (regs[i]) rdChk(regs[i], 32'h0000_0000);
    cmpIrq(1'b0);
    wr(A_BC, 32'hffff_ffff);
    rdChk(A_BC, 32'h0000_00ff);
    wr(A_LOW, 32'h0000_abcd, 4'h1);
    rdChk(A_LOW, 32'h0000_00cd);
    wr(12'h000, 32'h1234_5678);
    rdChk(12'h000, 32'h0000_0000);
    $display("test regs done");
  endtask

  task automatic testUp;
    wr(A_CFG, 32'h0000_0002);
    wr(A_IM, 32'h0000_0001);
    wr(A_LOW, 32'h0000_0005);
    wr(A_CTRL, 32'h0000_0003);
    rdChk(A_CNT, 32'h0000_0000);
    rdChk(A_ST, 32'h0000_0001);
    pulse(3);
    rdChk(A_CNT, 32'h0000_0003);
    src.pulses(2, 3, 4);
    pulse(0);
    rdChk(A_CNT, 32'h0000_0000);
    rdChk(A_IS, 32'h0000_0001);
    cmpIrq(1'b1);
    wr(A_IS, 32'h0000_0001);
    rdChk(A_IS, 32'h0000_0000);
    cmpIrq(1'b0);
    $display("test up done");
  endtask

  task automatic testStop;
    pulse(2);
    rdChk(A_CNT, 32'h0000_0002);
    wr(A_CTRL, 32'h0000_0001);
    pulse(3);
    rdChk(A_CNT, 32'h0000_0002);
    wr(A_CTRL, 32'h0000_0000);
    wr(A_CTRL, 32'h0000_0002);
    rdChk(A_CNT, 32'h0000_0002);
    pulse(1);
    rdChk(A_CNT, 32'h0000_0003);
    wr(A_CTRL, 32'h0000_0000);
    wr(A_CTRL, 32'h0000_0003);
    rdChk(A_CNT, 32'h0000_0000);
    $display("test stop done");
  endtask

  task automatic testRetarget;
    pulse(2);
    wr(A_LOW, 32'h0000_000a);
    wr(A_CTRL, 32'h0000_0002);
    wr(A_CTRL, 32'h0000_0003);
    rdChk(A_ST, 32'h0000_0003);
    rdChk(A_CNT, 32'h0000_0002);
    wr(A_IM, 32'h0000_0000);
    pulse(4);
    rdChk(A_CNT, 32'h0000_0006);
    rdChk(A_ST, 32'h0000_0001);
    pulse(3);
    rdChk(A_CNT, 32'h0000_0009);
    pulse(1);
    rdChk(A_CNT, 32'h0000_0000);
    rdChk(A_IS, 32'h0000_0001);
    cmpIrq(1'b0);
    wr(A_IM, 32'h0000_0001);
    rdChk(A_IM, 32'h0000_0001);
    cmpIrq(1'b1);
    wr(A_IS, 32'h0000_0001);
    rdChk(A_IS, 32'h0000_0000);
    cmpIrq(1'b0);
    wr(A_CTRL, 32'h0000_0000);
    $display("test retarget done");
  endtask

  task automatic testDown;
    wr(A_CFG, 32'h0000_0003);
    wr(A_LOW, 32'h0000_0003);
    wr(A_CTRL, 32'h0000_0003);
    rdChk(A_CNT, 32'h0000_0003);
    pulse(1);
    rdChk(A_CNT, 32'h0000_0002);
    wr(A_LOW, 32'h0000_0006);
    wr(A_CTRL, 32'h0000_0002);
    wr(A_CTRL, 32'h0000_0003);
    rdChk(A_CNT, 32'h0000_0002);
    pulse(1);
    rdChk(A_CNT, 32'h0000_0004);
    pulse(3);
    rdChk(A_CNT, 32'h0000_0001);
    rdChk(A_IS, 32'h0000_0000);
    pulse(1);
    rdChk(A_CNT, 32'h0000_0006);
    rdChk(A_IS, 32'h0000_0001);
    wr(A_IS, 32'h0000_0001);
    wr(A_CTRL, 32'h0000_0000);
    $display("test down done");
  endtask

  // terminal event without the interrupt option still reinitialises
  task automatic testNoIrq;
    wr(A_CFG, 32'h0000_0000);
    wr(A_LOW, 32'h0000_0002);
    wr(A_CTRL, 32'h0000_0003);
    pulse(1);
    rdChk(A_CNT, 32'h0000_0001);
    pulse(1);
    rdChk(A_CNT, 32'h0000_0000);
    rdChk(A_IS, 32'h0000_0000);
    cmpIrq(1'b0);
    $display("test no irq done");
  endtask

  // falling-edge option: the rise of a long pulse alone must not count
  task automatic testFall;
    wr(A_CFG, 32'h0000_0004);
    wr(A_LOW, 32'h0000_0007);
    wr(A_CTRL, 32'h0000_0000);
    wr(A_CTRL, 32'h0000_0003);
    fork
      src.pulses(1, 6, 1);
      begin
        repeat (3) @(posedge clk);
        rdChk(A_CNT, 32'h0000_0000);
      end
    join
    pulse(0);
    rdChk(A_CNT, 32'h0000_0001);
    wr(A_CTRL, 32'h0000_0000);
    $display("test fall done");
  endtask

  // reset held 16 cycles, then the scenarios in turn
  initial begin
    clk        = 1'b0;
    rst_n      = 1'b0;
    address    = 12'h000;
    read       = 1'b0;
    write      = 1'b0;
    writedata  = 32'h0000_0000;
    byteenable = 4'h0;
    nMismatch  = 0;
    compares   = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    testRegs();
    testUp();
    testStop();
    testRetarget();
    testDown();
    testNoIrq();
    testFall();
    conclude();
  end
endmodule // uicc_ctrl_tb
